/* File: hdl/ctm_mailbox.sv */
/*
 * can transmit mailbox register window behind a decoded modbus request port:
 * seven holding registers compose one frame, an eighth triggers it, a status block is streamed out.
 * assumes a protocol front end on the same clock that parses requests,
 * frames answers, and a can controller that takes tx_frame on tx_ready.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_mailbox
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire ctm_req_s req,
    output logic req_ready,
    input wire logic wr_valid,
    input wire logic [15:0] wr_word,
    output logic resp_valid,
    output ctm_req_s resp,
    output logic rd_valid,
    output logic [15:0] rd_word,
    output logic tx_valid,
    output ctm_frame_s tx_frame,
    input wire logic tx_ready
);
    ctm_state_e state, next_state;
    logic [15:0] out_reg [8];
    logic [15:0] next_out_reg [8];
    logic trig_seen, next_trig_seen;
    logic next_req_ready, next_resp_valid, next_rd_valid, next_tx_valid;
    ctm_req_s next_resp;
    logic [15:0] next_rd_word, ptr, next_ptr, left, next_left, tx_count, next_tx_count;
    ctm_frame_s next_tx_frame;
    logic take;

    function automatic logic [15:0] stat_word(input logic [4:0] ix, input logic [15:0] cnt,
                                              input logic busy, input logic [15:0] ctrl);
        case (ix)
            `CTM_STAT_IX_COUNT: stat_word = cnt;
            `CTM_STAT_IX_BUSY: stat_word = {15'h0000, busy};
            `CTM_STAT_IX_CTRL: stat_word = ctrl;
            `CTM_STAT_IX_ID: stat_word = `CTM_STAT_ID_WORD;
            default: stat_word = 16'h0000;
        endcase
    endfunction

    function automatic ctm_frame_s build_frame(input logic [15:0] r0, input logic [15:0] r1,
                                               input logic [15:0] r2, input logic [63:0] d);
        ctm_frame_s f;
        f.extended = r0[`CTM_CTRL_EXT_BIT];
        f.remote = r0[`CTM_CTRL_RTR_BIT];
        f.dlc = (r0[`CTM_CTRL_DLC_MSB:0] > `CTM_DLC_MAX) ? `CTM_DLC_MAX : r0[`CTM_CTRL_DLC_MSB:0];
        f.id = {r1, r2};
        f.data = d;
        return f;
    endfunction

    assign take = req_valid && req_ready;

    always_comb
    begin
        logic wr_en;
        logic [2:0] wr_ix;
        logic [15:0] wr_val;
        logic [16:0] span;
        wr_en = 1'b0;
        wr_ix = 3'h0;
        wr_val = 16'h0000;
        span = {1'b0, req.addr} + {1'b0, req.qty};
        next_state = state;
        next_out_reg = out_reg;
        next_trig_seen = trig_seen;
        next_resp_valid = 1'b0;
        next_resp = resp;
        next_rd_valid = 1'b0;
        next_rd_word = rd_word;
        next_ptr = ptr;
        next_left = left;
        next_tx_count = tx_count;
        next_tx_frame = tx_frame;
        next_tx_valid = tx_valid && !tx_ready;
        unique case (state)
            CTM_ST_IDLE:
            begin
                if (take)
                begin
                    next_resp = req;
                    if (req.func == `CTM_FC_WR_SINGLE)
                    begin
                        if (req.addr < `CTM_NUM_OUT_REGS)
                        begin
                            wr_en = 1'b1;
                            wr_ix = req.addr[2:0];
                            wr_val = req.qty;
                            next_resp_valid = 1'b1;
                        end
                        else
                        begin
                            next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_ADDR};
                            next_resp_valid = 1'b1;
                        end
                    end
                    else if (req.func == `CTM_FC_WR_MULTI)
                    begin
                        if (req.qty == 16'h0000 || req.qty > `CTM_NUM_OUT_REGS)
                        begin
                            next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_VALUE};
                            next_resp_valid = 1'b1;
                        end
                        else if (span > {1'b0, `CTM_NUM_OUT_REGS})
                        begin
                            next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_ADDR};
                            next_resp_valid = 1'b1;
                        end
                        else
                        begin
                            next_ptr = req.addr;
                            next_left = req.qty;
                            next_state = CTM_ST_WR;
                        end
                    end
                    else if (req.func == `CTM_FC_RD_INPUT)
                    begin
                        if (req.qty == 16'h0000 || req.qty > `CTM_STAT_WORDS)
                        begin
                            next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_VALUE};
                            next_resp_valid = 1'b1;
                        end
                        else if (req.addr < `CTM_STAT_BASE
                                 || span > {1'b0, `CTM_STAT_BASE + `CTM_STAT_WORDS})
                        begin
                            next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_ADDR};
                            next_resp_valid = 1'b1;
                        end
                        else
                        begin
                            next_resp_valid = 1'b1;
                            next_ptr = req.addr - `CTM_STAT_BASE;
                            next_left = req.qty;
                            next_state = CTM_ST_RD;
                        end
                    end
                    else
                    begin
                        next_resp = '{req.func | `CTM_EXC_FLAG, req.addr, `CTM_EXC_ILL_FUNC};
                        next_resp_valid = 1'b1;
                    end
                end
            end
            CTM_ST_WR:
            begin
                if (wr_valid)
                begin
                    wr_en = 1'b1;
                    wr_ix = ptr[2:0];
                    wr_val = wr_word;
                    next_ptr = ptr + 16'h0001;
                    next_left = left - 16'h0001;
                    if (left == 16'h0001)
                    begin
                        next_resp_valid = 1'b1;
                        next_state = CTM_ST_IDLE;
                    end
                end
            end
            CTM_ST_RD:
            begin
                next_rd_valid = 1'b1;
                next_rd_word = stat_word(ptr[4:0], tx_count, tx_valid, out_reg[`CTM_OFS_CTRL]);
                next_ptr = ptr + 16'h0001;
                next_left = left - 16'h0001;
                if (left == 16'h0001)
                begin
                    next_state = CTM_ST_IDLE;
                end
            end
        endcase
        if (wr_en)
        begin
            next_out_reg[wr_ix] = wr_val;
            // first trigger write after reset always sends, later only a changed value
            if (wr_ix == `CTM_OFS_TRIG && (!trig_seen || wr_val != out_reg[`CTM_OFS_TRIG]))
            begin
                next_trig_seen = 1'b1;
                next_tx_valid = 1'b1;
                next_tx_count = tx_count + 16'h0001;
                next_tx_frame = build_frame(out_reg[`CTM_OFS_CTRL], out_reg[`CTM_OFS_ID_HIGH],
                    out_reg[`CTM_OFS_ID_LOW], {out_reg[`CTM_OFS_DATA_12],
                    out_reg[`CTM_OFS_DATA_34], out_reg[`CTM_OFS_DATA_56],
                    out_reg[`CTM_OFS_DATA_78]});
            end
        end
        next_req_ready = (next_state == CTM_ST_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= CTM_ST_IDLE;
            out_reg <= '{default: `CTM_REG_RESET};
            trig_seen <= 1'b0;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp <= '0;
            rd_valid <= 1'b0;
            rd_word <= 16'h0000;
            ptr <= 16'h0000;
            left <= 16'h0000;
            tx_count <= 16'h0000;
            tx_valid <= 1'b0;
            tx_frame <= '0;
        end
        else
        begin
            state <= next_state;
            out_reg <= next_out_reg;
            trig_seen <= next_trig_seen;
            req_ready <= next_req_ready;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
            rd_valid <= next_rd_valid;
            rd_word <= next_rd_word;
            ptr <= next_ptr;
            left <= next_left;
            tx_count <= next_tx_count;
            tx_valid <= next_tx_valid;
            tx_frame <= next_tx_frame;
        end
    end

    chk_single_write_stores: assert property (@(posedge clk) disable iff (rst)
        take && req.func == `CTM_FC_WR_SINGLE && req.addr < `CTM_NUM_OUT_REGS
        |=> out_reg[$past(req.addr[2:0])] == $past(req.qty))
        else $error("single write did not store");
    chk_single_write_echo: assert property (@(posedge clk) disable iff (rst)
        take && req.func == `CTM_FC_WR_SINGLE && req.addr < `CTM_NUM_OUT_REGS
        |=> resp_valid && resp == $past(req))
        else $error("single write echo wrong");
    chk_trigger_sends: assert property (@(posedge clk) disable iff (rst)
        take && req.func == `CTM_FC_WR_SINGLE && req.addr == 16'h0007
        && req.qty != out_reg[`CTM_OFS_TRIG] |=> tx_valid && tx_count == $past(tx_count) + 16'h0001)
        else $error("trigger write sent no frame");
    chk_frame_id: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_valid) |-> tx_frame.id == {out_reg[`CTM_OFS_ID_HIGH], out_reg[`CTM_OFS_ID_LOW]})
        else $error("frame identifier wrong");
    chk_frame_data: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_valid) |-> tx_frame.data[63:48] == out_reg[`CTM_OFS_DATA_12]
        && tx_frame.data[15:0] == out_reg[`CTM_OFS_DATA_78])
        else $error("frame data order wrong");
    chk_frame_ctrl: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_valid) |-> tx_frame.dlc <= `CTM_DLC_MAX
        && tx_frame.extended == out_reg[`CTM_OFS_CTRL][`CTM_CTRL_EXT_BIT]
        && tx_frame.remote == out_reg[`CTM_OFS_CTRL][`CTM_CTRL_RTR_BIT])
        else $error("frame control decode wrong");
    chk_status_read: assert property (@(posedge clk) disable iff (rst)
        take && req.func == `CTM_FC_RD_INPUT && req.addr == `CTM_STAT_BASE
        && req.qty == `CTM_STAT_WORDS |=> resp_valid ##1 rd_valid [*8])
        else $error("status block not streamed");
    chk_multi_write_done: assert property (@(posedge clk) disable iff (rst)
        state == CTM_ST_WR && wr_valid && left == 16'h0001
        |=> resp_valid && resp.func == `CTM_FC_WR_MULTI && req_ready)
        else $error("multiple write not answered");
endmodule
`default_nettype wire

/* File: hdl/ctm_defs.svh */
/*
 * constants of the can transmit mailbox register window: function codes,
 * register indices, control word fields, status block placement.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH
`define CTM_FC_RD_INPUT 8'h04
`define CTM_FC_WR_SINGLE 8'h06
`define CTM_FC_WR_MULTI 8'h10
`define CTM_EXC_FLAG 8'h80
`define CTM_EXC_ILL_FUNC 16'h0001
`define CTM_EXC_ILL_ADDR 16'h0002
`define CTM_EXC_ILL_VALUE 16'h0003
`define CTM_OFS_CTRL 3'h0
`define CTM_OFS_ID_HIGH 3'h1
`define CTM_OFS_ID_LOW 3'h2
`define CTM_OFS_DATA_12 3'h3
`define CTM_OFS_DATA_34 3'h4
`define CTM_OFS_DATA_56 3'h5
`define CTM_OFS_DATA_78 3'h6
`define CTM_OFS_TRIG 3'h7
`define CTM_NUM_OUT_REGS 16'h0008
`define CTM_REG_RESET 16'h0000
`define CTM_CTRL_EXT_BIT 5
`define CTM_CTRL_RTR_BIT 4
`define CTM_CTRL_DLC_MSB 3
`define CTM_DLC_MAX 4'h8
`define CTM_STAT_BASE 16'h0b54
`define CTM_STAT_WORDS 16'h0017
`define CTM_STAT_IX_COUNT 5'h00
`define CTM_STAT_IX_BUSY 5'h01
`define CTM_STAT_IX_CTRL 5'h02
`define CTM_STAT_IX_ID 5'h16
// arbitrary value, identifies no real part
`define CTM_STAT_ID_WORD 16'h5a5a
`endif

/* File: hdl/ctm_pkg.sv */
/*
 * types of the can transmit mailbox register window.
 * assumes ctm_defs.svh on the include path.
 */
`include "ctm_defs.svh"
package ctm_pkg;
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] qty;
    } ctm_req_s;

    typedef struct packed {
        logic extended;
        logic remote;
        logic [3:0] dlc;
        logic [31:0] id;
        logic [63:0] data;
    } ctm_frame_s;

    typedef enum logic [2:0] {
        CTM_ST_IDLE = 3'b001,
        CTM_ST_WR = 3'b010,
        CTM_ST_RD = 3'b100
    } ctm_state_e;
endpackage

/* File: test/ctm_host_model.sv */
/*
 * host model: issues decoded requests to the mailbox one at a time.
 * assumes ctm_pkg compiled first and the mailbox on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_host_model
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire ctm_req_s resp,
    input wire logic rd_valid,
    input wire logic [15:0] rd_word,
    output logic req_valid,
    output ctm_req_s req,
    output logic wr_valid,
    output logic [15:0] wr_word
);
    ctm_req_s last;
    logic [15:0] rd_q[$];
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        wr_valid = 1'b0;
        wr_word = 16'h0000;
    end
    // released request fields are inverted so stale values never match
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
        input logic [15:0] w [0:7], input int n_rd);
        bit got;
        got = 1'b0;
        last = 'x;
        rd_q.delete();
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {f, a, q};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req <= ~req;
        if (f == `CTM_FC_WR_MULTI)
        begin
            wr_valid <= 1'b1;
            wr_word <= w[0];
        end
        // look just after each edge, the take edge included: answers are one-cycle pulses
        for (int k = 1; k < 40; k++)
        begin
            #1;
            if (resp_valid === 1'b1)
            begin
                got = 1'b1;
                last = resp;
            end
            if (rd_valid === 1'b1)
                rd_q.push_back(rd_word);
            if (got && rd_q.size() >= n_rd)
                break;
            @(posedge clk);
            if (wr_valid && k < q)
                wr_word <= w[k];
            else if (wr_valid)
            begin
                wr_valid <= 1'b0;
                wr_word <= ~wr_word;
            end
        end
        // a refused multiple write ends early, so drop the word strobe here
        if (wr_valid)
        begin
            @(posedge clk);
            wr_valid <= 1'b0;
            wr_word <= ~wr_word;
        end
    endtask
endmodule
`default_nettype wire

/* File: test/ctm_mailbox_bench.sv */
/*
 * bench for the can transmit mailbox: composes frames, triggers, reads status.
 * assumes ctm_pkg, ctm_mailbox and ctm_host_model compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_mailbox_bench import ctm_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tx_ready = 1'b0;
    logic req_valid, req_ready, wr_valid, resp_valid, rd_valid, tx_valid;
    logic [15:0] wr_word, rd_word;
    ctm_req_s req, resp;
    ctm_frame_s tx_frame;
    logic [15:0] nil [0:7] = '{default: 16'h0000};
    int n_fail = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    ctm_mailbox ctm_mailbox_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .wr_valid(wr_valid), .wr_word(wr_word),
        .resp_valid(resp_valid), .resp(resp), .rd_valid(rd_valid), .rd_word(rd_word),
        .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready));
    ctm_host_model ctm_host_model_i (.clk(clk), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp(resp), .rd_valid(rd_valid), .rd_word(rd_word),
        .req_valid(req_valid), .req(req), .wr_valid(wr_valid), .wr_word(wr_word));
    task automatic report(string n, bit ok, logic [127:0] e, logic [127:0] g);
        samples_checked++;
        if (!ok)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_word(string n, logic [15:0] e, logic [15:0] g);
        report(n, g === e, e, g);
    endtask
    task automatic cmp_flag(string n, logic e, logic g);
        report(n, g === e, e, g);
    endtask
    task automatic cmp_resp(string n, ctm_req_s e, ctm_req_s g);
        report(n, g === e, e, g);
    endtask
    task automatic cmp_frame(string n, ctm_frame_s e, ctm_frame_s g);
        report(n, g === e, e, g);
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr1(logic [15:0] a, logic [15:0] v);
        ctm_host_model_i.xfer(`CTM_FC_WR_SINGLE, a, v, nil, 0);
        cmp_resp("single write echo", {`CTM_FC_WR_SINGLE, a, v}, ctm_host_model_i.last);
    endtask
    // frame must stand while the controller stalls, then drop once taken
    task automatic tx_check(ctm_frame_s e);
        cmp_flag("tx_valid raised", 1'b1, tx_valid);
        cmp_frame("tx_frame", e, tx_frame);
        repeat (3) @(posedge clk);
        #1 cmp_flag("tx_valid held", 1'b1, tx_valid);
        @(posedge clk) tx_ready <= 1'b1;
        @(posedge clk) tx_ready <= 1'b0;
        #1 cmp_flag("tx_valid cleared", 1'b0, tx_valid);
    endtask
    initial
    begin
        ctm_frame_s f1;
        ctm_frame_s f2;
        ctm_frame_s f3;
        logic [15:0] ex [0:22];
        logic [7:0] ef [0:3];
        logic [15:0] ea [0:3];
        logic [15:0] ec [0:3];
        logic [15:0] eq [0:3];
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        f1 = {1'b1, 1'b1, 4'h5, 32'h12345678, 64'h1122334455667788};
        wr1(16'h0000, 16'h0035);
        wr1(16'h0001, 16'h1234);
        wr1(16'h0002, 16'h5678);
        wr1(16'h0003, 16'h1122);
        wr1(16'h0004, 16'h3344);
        wr1(16'h0005, 16'h5566);
        wr1(16'h0006, 16'h7788);
        wr1(16'h0007, 16'h0000);
        tx_check(f1);
        wr1(16'h0007, 16'h0000);
        repeat (2) @(posedge clk);
        #1 cmp_flag("tx_valid on same value", 1'b0, tx_valid);
        wr1(16'h0007, 16'h0001);
        tx_check(f1);
        // whole new frame and trigger in one multiple write
        f2 = {1'b0, 1'b0, 4'h8, 32'h000007ff, 64'ha1a2b1b2c1c2d1d2};
        ctm_host_model_i.xfer(`CTM_FC_WR_MULTI, 16'h0000, 16'h0008, '{16'h0008, 16'h0000,
            16'h07ff, 16'ha1a2, 16'hb1b2, 16'hc1c2, 16'hd1d2, 16'h0002}, 0);
        cmp_resp("multi echo", {8'h10, 16'h0000, 16'h0008}, ctm_host_model_i.last);
        tx_check(f2);
        for (int i = 0; i < 23; i++)
            ex[i] = 16'h0000;
        ex[0] = 16'h0003;
        ex[2] = 16'h0008;
        ex[22] = `CTM_STAT_ID_WORD;
        ctm_host_model_i.xfer(`CTM_FC_RD_INPUT, 16'h0b54, 16'h0017, nil, 23);
        cmp_resp("status echo", {8'h04, 16'h0b54, 16'h0017}, ctm_host_model_i.last);
        cmp_word("status count", 16'h0017, 16'(ctm_host_model_i.rd_q.size()));
        for (int i = 0; i < 23; i++)
            cmp_word("status word", ex[i], ctm_host_model_i.rd_q[i]);
        // length field above eight is sent as eight
        f3 = {1'b0, 1'b0, 4'h8, 32'h000007ff, 64'ha1a2b1b2c1c2d1d2};
        wr1(16'h0000, 16'h000f);
        wr1(16'h0007, 16'h0003);
        tx_check(f3);
        ef = '{8'h03, 8'h04, 8'h06, 8'h10};
        ea = '{16'h0000, 16'h0b6b, 16'h0008, 16'h0000};
        ec = '{16'h0001, 16'h0002, 16'h0002, 16'h0003};
        eq = '{16'h0001, 16'h0001, 16'h0001, 16'h0009};
        for (int i = 0; i < 4; i++)
        begin
            ctm_host_model_i.xfer(ef[i], ea[i], eq[i], nil, 0);
            cmp_resp("exception", {ef[i] | 8'h80, ea[i], ec[i]}, ctm_host_model_i.last);
        end
        stop_test();
    end
    initial
    begin
        #(40 * 4000);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
